// ===== inc/i2s_audio_pkg.sv
// Constants and carrier types for the stereo serial audio port
`default_nettype none
package i2s_audio_pkg;
    // System clock and nominal frame figures
    localparam int unsigned SYS_CLK_HZ    = 32'h05F5_E100; // 100 MHz
    localparam int unsigned FRAME_RATE_HZ = 32'h0000_BB80; // 48 kHz
    localparam int unsigned FRAME_32_BITS = 32'h0000_0020;
    localparam int unsigned FRAME_50_BITS = 32'h0000_0032;
    localparam int unsigned BCLK_32_HZ    = FRAME_RATE_HZ * FRAME_32_BITS;
    localparam int unsigned BCLK_50_HZ    = FRAME_RATE_HZ * FRAME_50_BITS;
    localparam int unsigned SLAVE_MAX_HZ  = 32'h002E_E000; // 3.072 MHz
    // Shortest slave half period in system cycles, rounded down
    localparam int unsigned SLAVE_HALF_CYC = SYS_CLK_HZ / (2 * SLAVE_MAX_HZ);

    localparam int unsigned WORD_BITS  = 32'h0000_0010;
    localparam int unsigned HALF_32    = FRAME_32_BITS / 2;
    localparam int unsigned HALF_50    = FRAME_50_BITS / 2;
    localparam int unsigned CNT_W      = 32'h0000_0005;
    localparam int unsigned FIFO_DEPTH = 32'h0000_0010;
    localparam int unsigned DIV_W      = 32'h0000_0010;

    // Toggle rate = SYS_CLK_HZ * num / den, bit clock is half of it
    localparam logic [15:0] DIV_NUM_32 = 16'h0060; // 96 / 3125
    localparam logic [15:0] DIV_DEN_32 = 16'h0C35;
    localparam logic [15:0] DIV_NUM_50 = 16'h0006; // 6 / 125
    localparam logic [15:0] DIV_DEN_50 = 16'h007D;

    typedef struct packed {
        logic [WORD_BITS-1:0] right;
        logic [WORD_BITS-1:0] left;
    } stereo_t;
endpackage
`default_nettype wire

// ===== rtl/i2s_audio_port.sv
// Stereo serial audio port with transmit FIFO, master divider and receiver
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module audio_fifo #(
    parameter int unsigned WIDTH = 32,
    parameter int unsigned DEPTH = 16
) (
    input  wire logic             clk_sys,  // System clock
    input  wire logic             rst_n,    // Sync reset, active low
    input  wire logic             wrValid,  // Write request
    output var  logic             wrReady,  // Room for a word
    input  wire logic [WIDTH-1:0] wrData,   // Write word
    output var  logic             rdValid,  // Word available
    input  wire logic             rdReady,  // Pop request
    output var  logic [WIDTH-1:0] rdData    // Head word
);
    localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wrPtr_reg;
    logic [PW-1:0]    rdPtr_reg;
    logic [PW:0]      count_reg;
    logic             ready_reg;
    wire              doWr = wrValid && ready_reg;
    wire              doRd = rdReady && (count_reg != '0);
    wire [PW:0]       count_next = count_reg + (PW+1)'(doWr) - (PW+1)'(doRd);

    assign wrReady = ready_reg;
    assign rdValid = count_reg != '0;
    assign rdData  = mem[rdPtr_reg];

    always_ff @(posedge clk_sys) begin
        if (doWr) begin
            mem[wrPtr_reg] <= wrData;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            count_reg <= '0;
            ready_reg <= 1'b1;
        end else begin
            if (doWr) begin
                wrPtr_reg <= (wrPtr_reg == LAST) ? '0 : wrPtr_reg + 1'b1;
            end
            if (doRd) begin
                rdPtr_reg <= (rdPtr_reg == LAST) ? '0 : rdPtr_reg + 1'b1;
            end
            count_reg <= count_next;
            // Registered so the source sees a flop-driven ready
            ready_reg <= count_next != (PW+1)'(DEPTH);
        end
    end
endmodule // audio_fifo

////////////////////////////////////////////////////////////////////////////////
module i2s_audio_port #(
    parameter int unsigned TX_DEPTH = 16
) (
    input  wire logic                  clk_sys,    // 100 MHz system clock
    input  wire logic                  rst_n,      // Sync reset, active low
    input  wire logic                  masterMode, // 1 master, 0 slave
    input  wire logic                  frame50,    // 1 for 50-bit frame
    input  wire logic [15:0]           divNum,     // Divider numerator
    input  wire logic [15:0]           divDen,     // Divider denominator
    input  wire logic                  txValid,    // Stereo pair offered
    input  wire i2s_audio_pkg::stereo_t txData,    // Pair to send
    output var  logic                  txReady,    // FIFO has room
    output var  logic                  txUnderrun, // Left slot sent empty
    output var  logic                  rxValid,    // Pair received, pulse
    output var  i2s_audio_pkg::stereo_t rxData,    // Received pair
    input  wire logic                  sckIn,      // Bit clock, slave
    output var  logic                  sckOut,     // Bit clock, master
    output var  logic                  sckOe_n,    // Bit clock enable
    input  wire logic                  wsIn,       // Word select, slave
    output var  logic                  wsOut,      // Word select, master
    output var  logic                  wsOe_n,     // Word select enable
    input  wire logic                  sdi,        // Serial data in
    output var  logic                  sdo         // Serial data out
);
    import i2s_audio_pkg::*;

    localparam logic [CNT_W-1:0] IDLE_IDX = CNT_W'(WORD_BITS);
    localparam logic [CNT_W-1:0] LAST_BIT = CNT_W'(WORD_BITS - 1);
    localparam logic [CNT_W-1:0] LAST_32  = CNT_W'(HALF_32 - 1);
    localparam logic [CNT_W-1:0] LAST_50  = CNT_W'(HALF_50 - 1);

    logic [DIV_W-1:0]     divAcc_reg;
    logic                 sckOut_reg, sckPrev_reg, wsOut_reg, oe_n_reg;
    logic [CNT_W-1:0]     halfCnt_reg;
    logic                 txLastWs_reg, sdo_reg, underrun_reg;
    logic [WORD_BITS-1:0] txShift_reg, rightHold_reg;
    logic [CNT_W-1:0]     txIdx_reg;
    logic                 rxLastWs_reg, rxValid_reg;
    logic [WORD_BITS-1:0] rxShift_reg, leftHold_reg;
    logic [CNT_W-1:0]     rxCnt_reg;
    stereo_t              rxData_reg, fifoOut;
    logic                 fifoValid;

    ////////////////////////////////////////////////////////////////////////////
    // Fractional divider: accumulator steps by N, wraps at M
    wire [DIV_W:0]   divSum  = {1'b0, divAcc_reg} + {1'b0, divNum};
    wire             divTick = divSum >= {1'b0, divDen};
    wire [DIV_W-1:0] divAcc_next = divTick ?
                         DIV_W'(divSum - {1'b0, divDen}) : divSum[DIV_W-1:0];

    // Edge strobes; slave inputs are sampled at 100 MHz, ample for 3.072 MHz
    wire txFall = masterMode ? (divTick && sckOut_reg)
                             : (sckPrev_reg && !sckIn);
    wire rxRise = masterMode ? (divTick && !sckOut_reg)
                             : (!sckPrev_reg && sckIn);
    wire lineWs = masterMode ? wsOut_reg : wsIn;
    wire [CNT_W-1:0] halfLast = frame50 ? LAST_50 : LAST_32;

    always_ff @(posedge clk_sys) begin
        if (!rst_n || !masterMode) begin
            divAcc_reg <= '0;
            sckOut_reg <= 1'b0;
        end else begin
            divAcc_reg <= divAcc_next;
            sckOut_reg <= sckOut_reg ^ divTick;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sckPrev_reg <= 1'b0;
            oe_n_reg    <= 1'b1;
            wsOut_reg   <= 1'b0;
            halfCnt_reg <= '0;
        end else begin
            sckPrev_reg <= sckIn;
            oe_n_reg    <= !masterMode;
            if (!masterMode) begin
                halfCnt_reg <= '0;
            end else if (txFall) begin
                // Word select flips on a falling edge every half frame
                halfCnt_reg <= (halfCnt_reg == halfLast) ? '0
                                                         : halfCnt_reg + 1'b1;
                wsOut_reg   <= wsOut_reg ^ (halfCnt_reg == halfLast);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transmit: word select as latched at the last rise; a change there
    // loads the MSB at the next fall, so a partner that moves it with the
    // falling edge still gets its MSB one bit later
    wire                 txWs     = rxLastWs_reg;
    wire                 txChange = txWs != txLastWs_reg;
    wire [WORD_BITS-1:0] leftPick = fifoValid ? fifoOut.left : '0;
    wire [WORD_BITS-1:0] loadWord = txWs ? rightHold_reg : leftPick;
    wire                 popPair  = txFall && txChange && !txWs;

    audio_fifo #(
        .WIDTH ($bits(stereo_t)),
        .DEPTH (TX_DEPTH)
    ) u_txFifo (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .wrValid (txValid),
        .wrReady (txReady),
        .wrData  (txData),
        .rdValid (fifoValid),
        .rdReady (popPair),
        .rdData  (fifoOut)
    );

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            txLastWs_reg  <= 1'b0;
            sdo_reg       <= 1'b0;
            txShift_reg   <= '0;
            txIdx_reg     <= IDLE_IDX;
            rightHold_reg <= '0;
            underrun_reg  <= 1'b0;
        end else begin
            underrun_reg <= popPair && !fifoValid;
            if (txFall) begin
                txLastWs_reg <= txWs;
                if (txChange) begin
                    sdo_reg     <= loadWord[WORD_BITS-1];
                    txShift_reg <= {loadWord[WORD_BITS-2:0], 1'b0};
                    txIdx_reg   <= CNT_W'(1);
                end else begin
                    // Shifting in zeros pads the slot past 16 bits
                    sdo_reg     <= txShift_reg[WORD_BITS-1];
                    txShift_reg <= {txShift_reg[WORD_BITS-2:0], 1'b0};
                    txIdx_reg   <= (txIdx_reg >= IDLE_IDX) ? txIdx_reg
                                                           : txIdx_reg + 1'b1;
                end
                if (popPair) begin
                    rightHold_reg <= fifoValid ? fifoOut.right : '0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Receive: count restarts after the rise that sees word select change
    wire                 rxChange = lineWs != rxLastWs_reg;
    wire                 rxTake   = rxRise && (rxCnt_reg < IDLE_IDX);
    wire                 rxDone   = rxTake && (rxCnt_reg == LAST_BIT);
    wire [WORD_BITS-1:0] rxWord   = {rxShift_reg[WORD_BITS-2:0], sdi};

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rxLastWs_reg <= 1'b0;
            rxShift_reg  <= '0;
            rxCnt_reg    <= IDLE_IDX;
            leftHold_reg <= '0;
            rxData_reg   <= '0;
            rxValid_reg  <= 1'b0;
        end else begin
            rxValid_reg <= rxDone && rxLastWs_reg;
            if (rxTake) begin
                rxShift_reg <= rxWord;
            end
            if (rxRise) begin
                rxLastWs_reg <= lineWs;
                rxCnt_reg    <= rxChange ? '0 :
                                (rxCnt_reg >= IDLE_IDX) ? rxCnt_reg
                                                        : rxCnt_reg + 1'b1;
            end
            if (rxDone && !rxLastWs_reg) begin
                leftHold_reg <= rxWord;
            end
            if (rxDone && rxLastWs_reg) begin
                rxData_reg <= '{right: rxWord, left: leftHold_reg};
            end
        end
    end

    assign sckOut     = sckOut_reg;
    assign sckOe_n    = oe_n_reg;
    assign wsOut      = wsOut_reg;
    assign wsOe_n     = oe_n_reg;
    assign sdo        = sdo_reg;
    assign txUnderrun = underrun_reg;
    assign rxValid    = rxValid_reg;
    assign rxData     = rxData_reg;

    ////////////////////////////////////////////////////////////////////////////
    AST_OE_MODE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        masterMode[*2] |-> !sckOe_n && !wsOe_n)
        else $error("pin enables not active in master mode");
    AST_OE_SLAVE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !masterMode ##1 !masterMode |-> sckOe_n && wsOe_n)
        else $error("pin enables active in slave mode");
    AST_SDO_FALL: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $changed(sdo) |-> $past(txFall))
        else $error("serial data moved outside a falling edge");
    AST_MSB_DELAY: assert property (@(posedge clk_sys) disable iff (!rst_n)
        txFall && txChange |=> sdo == $past(loadWord[WORD_BITS-1]))
        else $error("word MSB not sent after word select change");
    AST_LEFT_LOW: assert property (@(posedge clk_sys) disable iff (!rst_n)
        txFall && txChange && !txWs && fifoValid |-> loadWord == fifoOut.left)
        else $error("left word not loaded while word select low");
    AST_PAD_ZERO: assert property (@(posedge clk_sys) disable iff (!rst_n)
        txFall && !txChange && txIdx_reg >= IDLE_IDX |=> !sdo)
        else $error("padding bit not zero");
    AST_HALF_LEN: assert property (@(posedge clk_sys) disable iff (!rst_n)
        masterMode && $past(masterMode) && $changed(wsOut_reg)
        |-> $past(halfCnt_reg) == $past(halfLast) && $past(txFall))
        else $error("word select toggled at wrong bit count");
    AST_DIV_EDGE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        masterMode && $past(masterMode) && $changed(sckOut_reg) |-> $past(divTick))
        else $error("bit clock moved without divider tick");
    AST_RX_PAIR: assert property (@(posedge clk_sys) disable iff (!rst_n)
        rxDone && rxLastWs_reg |=> rxValid && rxData.right == $past(rxWord))
        else $error("received right word not delivered");
    AST_WORD_LEN: assert property (@(posedge clk_sys) disable iff (!rst_n)
        txFall && txChange |=> txIdx_reg == CNT_W'(1))
        else $error("word bit index not restarted");
endmodule // i2s_audio_port
`default_nettype wire

// ===== verification/audio_codec_model.sv
// Behavioural codec on the far side of the serial audio port
`timescale 1ns/100ps
`default_nettype none
module audio_codec_model #(
    parameter int HALF = 17 // 2.94 MHz, just under the slave ceiling
) (
    input  wire logic        clk_sys,    // System clock
    input  wire logic        rst_n,      // Sync reset, active low
    input  wire logic        slaveRun,   // Run our own bit clock
    input  wire logic        masterMode, // Port makes the clocks
    input  wire logic        sckOut,     // Port bit clock
    input  wire logic        wsOut,      // Port word select
    output logic             sckIn,      // Our bit clock
    output logic             wsIn,       // Our word select
    output logic             sdi,        // Our serial data
    input  wire logic        sdo,        // Port serial data
    input  wire logic [31:0] sendPair,   // Pair we send
    output logic      [31:0] gotPair,    // Pair we heard
    output int               halfBits,   // Length of last slot
    output int               padErr,     // Ones seen past bit 16
    output int               edgeErr     // Data moved away from a fall
);
    logic        bPrev, wsLast, wsFall, sdoPrev;
    logic [15:0] acc, cur;
    int          cnt, fb, kk, jj, since;
    wire  logic  bclk = masterMode ? sckOut : sckIn;
    wire  logic  ws   = masterMode ? wsOut : wsIn;

    initial begin
        sckIn = 1'b0;
        wsIn = 1'b0;
        sdi = 1'b0;
        padErr = 0;
        edgeErr = 0;
    end

    // Edges found from clk samples, so no race with the port's registers
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            cnt = 0;
            fb = 0;
            kk = 0;
            since = 0;
            jj = 16;
            {wsLast, wsFall, bPrev} = {ws, ws, bclk};
            sckIn <= 1'b0;
            wsIn <= 1'b0;
        end else begin
            if (bPrev && !bclk) begin
                since = 0;
                sdi <= (jj < 16) ? cur[15-jj] : 1'b0;
                jj++;
                if (ws !== wsFall) begin
                    jj = 0;
                    cur = ws ? sendPair[31:16] : sendPair[15:0];
                    wsFall = ws;
                end
            end
            if (sdo !== sdoPrev && since > 6) edgeErr++;
            since++;
            if (!bPrev && bclk) begin
                if (kk < 16) acc[15-kk] = sdo;
                else if (sdo) padErr++;
                kk++;
                if (ws !== wsLast) begin
                    halfBits = kk;
                    if (wsLast) gotPair[31:16] = acc;
                    else gotPair[15:0] = acc;
                    kk = 0;
                    wsLast = ws;
                end
            end
            // Clock stands still between runs
            if (slaveRun && ++cnt == HALF) begin
                cnt = 0;
                sckIn <= !sckIn;
                if (sckIn && ++fb == 16) begin
                    fb = 0;
                    wsIn <= !wsIn;
                end
            end
        end
        bPrev = bclk;
        sdoPrev = sdo;
    end
endmodule // audio_codec_model
`default_nettype wire

// ===== verification/tb_i2s_audio_port.sv
// Self-checking bench for the stereo serial audio port
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin failures++; \
    $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module tb_i2s_audio_port;
    import i2s_audio_pkg::*;
    localparam stereo_t SEND = 32'h8421_F00F;
    localparam stereo_t PAIR = 32'hC0D5_1357;
    logic        clk_sys = 0, rst_n = 0, masterMode = 0, frame50 = 0;
    logic        txValid = 0, slaveRun = 0;
    logic [15:0] divNum = DIV_NUM_32, divDen = DIV_DEN_32;
    stereo_t     txData = PAIR, rxData, gotPair;
    logic        txReady, txUnderrun, rxValid, sckIn, sckOut, sckOe_n;
    logic        wsIn, wsOut, wsOe_n, sdi, sdo;
    int          failures = 0, compares = 0, underCnt, halfBits, padErr;
    int          edgeErr, n;
    wire  logic  wsBus = masterMode ? wsOut : wsIn;

    i2s_audio_port #(.TX_DEPTH(FIFO_DEPTH)) u_i2s_audio_port (
        .clk_sys(clk_sys), .rst_n(rst_n), .masterMode(masterMode),
        .frame50(frame50), .divNum(divNum), .divDen(divDen),
        .txValid(txValid), .txData(txData), .txReady(txReady),
        .txUnderrun(txUnderrun), .rxValid(rxValid), .rxData(rxData),
        .sckIn(sckIn), .sckOut(sckOut), .sckOe_n(sckOe_n), .wsIn(wsIn),
        .wsOut(wsOut), .wsOe_n(wsOe_n), .sdi(sdi), .sdo(sdo));
    audio_codec_model u_audio_codec_model (
        .clk_sys(clk_sys), .rst_n(rst_n), .slaveRun(slaveRun),
        .masterMode(masterMode), .sckOut(sckOut), .wsOut(wsOut),
        .sckIn(sckIn), .wsIn(wsIn), .sdi(sdi), .sdo(sdo),
        .sendPair(SEND), .gotPair(gotPair), .halfBits(halfBits),
        .padErr(padErr), .edgeErr(edgeErr));

    always #5 clk_sys = !clk_sys;
    always @(negedge clk_sys) if (txUnderrun === 1'b1) underCnt++;

    task automatic give_verdict();
        if (failures == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic do_reset(input logic f);
        @(negedge clk_sys);
        rst_n = 0;
        masterMode = 0;
        slaveRun = 0;
        frame50 = f;
        divNum = f ? DIV_NUM_50 : DIV_NUM_32;
        divDen = f ? DIV_DEN_50 : DIV_DEN_32;
        repeat (2) @(negedge clk_sys);
        rst_n = 1;
        underCnt = 0;
    endtask
    // Offers the same pair for k edges and counts what was taken
    task automatic push(input int k);
        n = 0;
        @(negedge clk_sys);
        txValid = 1;
        repeat (k) begin
            // Ready seen between edges is what the next edge acts on
            if (txReady === 1'b1) n++;
            @(negedge clk_sys);
        end
        txValid = 0;
    endtask
    // Leaves n holding the cycles since the previous rise
    task automatic wait_ws(input int frames);
        repeat (frames) begin
            n = 0;
            while (wsBus !== 1'b0 && n < 4000) begin
                @(negedge clk_sys);
                n++;
            end
            while (wsBus !== 1'b1 && n < 4000) begin
                @(negedge clk_sys);
                n++;
            end
            `CHK("wsRise", 1'b1, n < 4000)
        end
    endtask
    task automatic wait_rx();
        n = 0;
        do begin
            @(negedge clk_sys);
            n++;
        end while (rxValid !== 1'b1 && n < 4000);
        `CHK("rxData", SEND, rxData)
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_slave();
        do_reset(1'b0);
        `CHK("sdo", 1'b0, sdo)
        push(20);
        `CHK("accepted", FIFO_DEPTH, n)
        `CHK("txReady", 1'b0, txReady)
        `CHK("sckOe_n", 1'b1, sckOe_n)
        `CHK("wsOe_n", 1'b1, wsOe_n)
        slaveRun = 1;
        wait_ws(2);
        `CHK("frameLen", 32 * 2 * 17, n)
        wait_rx();
        wait_rx();
        `CHK("txPair", PAIR, gotPair)
        `CHK("txReady", 1'b1, txReady)
        wait_ws(18);
        `CHK("underrun", 1'b1, underCnt > 0)
        `CHK("zeroPair", 32'h0000_0000, gotPair)
        slaveRun = 0;
    endtask
    task automatic t_master(input logic f);
        do_reset(f);
        `CHK("sckOe_n", 1'b1, sckOe_n)
        push(8);
        `CHK("accepted", 8, n)
        masterMode = 1;
        repeat (2) @(negedge clk_sys);
        `CHK("sckOe_n", 1'b0, sckOe_n)
        `CHK("wsOe_n", 1'b0, wsOe_n)
        wait_ws(2);
        `CHK("frameLen", 1'b1, n > 2043 && n < 2123)
        wait_rx();
        wait_rx();
        `CHK("halfBits", f ? 25 : 16, halfBits)
        `CHK("txPair", PAIR, gotPair)
        wait_ws(10);
        `CHK("underrun", 1'b1, underCnt > 0)
        `CHK("zeroPair", 32'h0000_0000, gotPair)
        `CHK("padErr", 0, padErr)
        `CHK("edgeErr", 0, edgeErr)
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        t_slave();
        t_master(1'b0);
        t_master(1'b1);
        give_verdict();
    end
    // Runs take about 0.74 ms; the limit keeps a hang under 100k cycles
    initial begin
        #1_000_000;
        failures++;
        give_verdict();
    end
endmodule // tb_i2s_audio_port
`default_nettype wire
